// *** rtl/metering_frontend_config_regs.sv ***
// Behaviour
// R1: Gain bits 7:5 set voltage gain: codes 000..100 give 1,2,4,8,16.
// R2: Gain bits 2:0 set current gain with the same code mapping.
// R3: Gain bit 3 picks sign detection: 0 filtered power, 1 per pulse.
// R4: First zero-cross enable drives zero-crossing onto pin P1.2; else undriven.
// R5: Second zero-cross enable drives pin P0.5, independent of the first.
// R6: Current select codes 00 and 11 follow automatic tamper-based choice.
// R7: Current select 01 forces input A, 10 forces input B.
// R8: Calibration bit 3 set grounds the voltage channel input.
// R9: Calibration bit 2 set grounds the current channel input.
// R10: Software writes zeros to calibration bits 7:6 and 1:0.
// R11: All gain and calibration fields reset to zero.
// R12: Accumulation-mode bit 7 reads the input used by antitamper: 0 A, 1 B.
// R13: Gain codes 101 to 111 act as unity gain.
`timescale 1ns/1ps
`default_nettype none
module metering_frontend_config_regs (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [metering_cfg_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [metering_cfg_pkg::DATA_W-1:0] hwdata,
	input wire logic hready,
	input wire logic tamper_auto_b,
	input wire logic zero_cross_level,
	output logic hreadyout,
	output logic hresp,
	output logic [metering_cfg_pkg::DATA_W-1:0] hrdata,
	output logic [metering_cfg_pkg::GAIN_W-1:0] voltage_gain,
	output logic [metering_cfg_pkg::GAIN_W-1:0] current_gain,
	output logic sign_detect_source,
	output logic meas_use_input_b,
	output logic voltage_input_ground,
	output logic current_input_ground,
	output logic [metering_cfg_pkg::ZX_PINS-1:0] zx_pin_out,
	output logic [metering_cfg_pkg::ZX_PINS-1:0] zx_pin_oe
);
	import metering_cfg_pkg::*;

	bus_req_t bus_req;
	gain_cfg_t gain_reg;
	zx_cfg_t zx_cfg_reg;
	cal_cfg_t cal_reg;
	logic tamper_channel_indicator_reg;
	logic [DATA_W-1:0] rd_word;
	gain_cfg_t wr_gain_view;

	// Register index match, shared by writes and reads
	function automatic logic reg_hit(
		input logic [IDX_W-1:0] idx,
		input logic [IDX_W-1:0] target
	);
		reg_hit = (idx == target);
	endfunction : reg_hit

	// Resolved current input for energy measurement
	function automatic logic pick_input_b(
		input logic [1:0] sel,
		input logic auto_b
	);
		if (sel == SEL_FORCE_A) begin
			pick_input_b = 1'b0;
		end else if (sel == SEL_FORCE_B) begin
			pick_input_b = 1'b1;
		end else begin
			pick_input_b = auto_b;
		end
	endfunction : pick_input_b

	// Bus front end
	ahb_reg_slave u_slave (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.rd_word(rd_word),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.bus_req(bus_req)
	);

	// Gain register; reserved bit 4 is never stored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gain_reg <= gain_cfg_t'(GAIN_RESET); // see R11
		end else if (ce && bus_req.wr_en && reg_hit(bus_req.idx, REG_IDX_GAIN)) begin
			gain_reg <= gain_cfg_t'(bus_req.wdata & GAIN_WRITE_MASK);
		end
	end

	// Zero-crossing output enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zx_cfg_reg <= zx_cfg_t'(ZX_RESET);
		end else if (ce && bus_req.wr_en && reg_hit(bus_req.idx, REG_IDX_ZX)) begin
			zx_cfg_reg <= zx_cfg_t'(bus_req.wdata & ZX_WRITE_MASK);
		end
	end

	// Calibration register; reserved bits held at zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cal_reg <= cal_cfg_t'(CAL_RESET); // see R11
		end else if (ce && bus_req.wr_en && reg_hit(bus_req.idx, REG_IDX_CAL)) begin
			cal_reg <= cal_cfg_t'(bus_req.wdata & CAL_WRITE_MASK); // see R10
		end
	end

	// Channel gains to the analog front end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			voltage_gain <= GAIN_X1;
			current_gain <= GAIN_X1;
		end else if (ce) begin
			voltage_gain <= gain_of(gain_reg.voltage_gain_sel); // see R1 see R13
			current_gain <= gain_of(gain_reg.current_gain_sel); // see R2 see R13
		end
	end

	// Sign-change detection point for the pulse outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sign_detect_source <= 1'b0;
		end else if (ce) begin
			sign_detect_source <= gain_reg.sign_detect_source; // see R3
		end
	end

	// Current input choice for energy measurement
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meas_use_input_b <= 1'b0;
		end else if (ce) begin
			meas_use_input_b <= pick_input_b(cal_reg.current_input_select, tamper_auto_b); // see R6 see R7
		end
	end

	// Calibration grounding of either channel
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			voltage_input_ground <= 1'b0;
			current_input_ground <= 1'b0;
		end else if (ce) begin
			voltage_input_ground <= cal_reg.voltage_input_ground; // see R8
			current_input_ground <= cal_reg.current_input_ground; // see R9
		end
	end

	// Input picked by the tamper logic, as software sees it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tamper_channel_indicator_reg <= 1'b0;
		end else if (ce) begin
			tamper_channel_indicator_reg <= tamper_auto_b; // see R12
		end
	end

	// Zero-crossing pin drivers, one per enable bit
	genvar gi;
	generate
		for (gi = 0; gi < ZX_PINS; gi++) begin : g_zx
			zx_pin_driver u_zx (
				.hclk(hclk),
				.hresetn(hresetn),
				.ce(ce),
				.enable(zx_cfg_reg.pin_en[gi]), // see R4 see R5
				.level(zero_cross_level),
				.pin_out(zx_pin_out[gi]),
				.pin_oe(zx_pin_oe[gi])
			);
		end
	endgenerate

	// Read data; unmapped words read zero
	always_comb begin
		rd_word = '0;
		if (reg_hit(bus_req.idx, REG_IDX_GAIN)) begin
			rd_word[REG_W-1:0] = gain_reg;
		end else if (reg_hit(bus_req.idx, REG_IDX_ZX)) begin
			rd_word[REG_W-1:0] = zx_cfg_reg;
		end else if (reg_hit(bus_req.idx, REG_IDX_CAL)) begin
			rd_word[REG_W-1:0] = cal_reg;
		end else if (reg_hit(bus_req.idx, REG_IDX_ACC_MODE)) begin
			rd_word[ACC_ICH_BIT] = tamper_channel_indicator_reg; // see R12
		end
	end

	// Write data seen through the gain field layout
	assign wr_gain_view = gain_cfg_t'(bus_req.wdata);

	// Voltage gain is always a single power of two
	AST_VGAIN_MAP: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
		ce |=> $onehot(voltage_gain))
		else $error("voltage gain not a power of two");

	// Voltage code 100 gives sixteen
	AST_VGAIN_X16: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
		ce && gain_reg.voltage_gain_sel == GAIN_CODE_X16 |=> voltage_gain == GAIN_X16)
		else $error("voltage gain code 100 not x16");

	// Written current gain code reaches its output two edges on
	AST_GAIN_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // see R2
		bus_req.wr_en && reg_hit(bus_req.idx, REG_IDX_GAIN)
		&& wr_gain_view.current_gain_sel == GAIN_CODE_X8 ##1 ce
		|=> current_gain == GAIN_X8)
		else $error("current gain did not follow written code");

	// Undefined codes give unity
	AST_GAIN_UNDEF: assert property (@(posedge hclk) disable iff (!hresetn) // see R13
		ce && gain_reg.current_gain_sel > GAIN_CODE_X16 |=> current_gain == GAIN_X1)
		else $error("undefined current gain code not unity");

	// Sign detection source tracks bit 3
	AST_SIGN_SRC: assert property (@(posedge hclk) disable iff (!hresetn) // see R3
		ce |=> sign_detect_source == $past(gain_reg.sign_detect_source))
		else $error("sign detection source wrong");

	// First zero-cross pin driven only when enabled
	AST_ZX_P12: assert property (@(posedge hclk) disable iff (!hresetn) // see R4
		ce |=> zx_pin_oe[ZX_PIN_P12] == $past(zx_cfg_reg.pin_en[ZX_PIN_P12])
		&& (zx_pin_out[ZX_PIN_P12] == ($past(zero_cross_level) && zx_pin_oe[ZX_PIN_P12])))
		else $error("P1.2 zero-cross drive wrong");

	// Second zero-cross pin independent of the first
	AST_ZX_P05: assert property (@(posedge hclk) disable iff (!hresetn) // see R5
		ce |=> zx_pin_oe[ZX_PIN_P05] == $past(zx_cfg_reg.pin_en[ZX_PIN_P05]))
		else $error("P0.5 zero-cross enable wrong");

	// Automatic selection follows the tamper logic
	AST_SEL_AUTO: assert property (@(posedge hclk) disable iff (!hresetn) // see R6
		ce && cal_reg.current_input_select != SEL_FORCE_A
		&& cal_reg.current_input_select != SEL_FORCE_B
		|=> meas_use_input_b == $past(tamper_auto_b))
		else $error("automatic current input not followed");

	// Forced selection overrides tamper logic
	AST_SEL_FORCE: assert property (@(posedge hclk) disable iff (!hresetn) // see R7
		ce && (cal_reg.current_input_select == SEL_FORCE_A
		|| cal_reg.current_input_select == SEL_FORCE_B)
		|=> meas_use_input_b == ($past(cal_reg.current_input_select) == SEL_FORCE_B))
		else $error("forced current input wrong");

	// Channel grounding follows calibration bits
	AST_GROUND: assert property (@(posedge hclk) disable iff (!hresetn) // see R8
		ce |=> voltage_input_ground == $past(cal_reg.voltage_input_ground)
		&& current_input_ground == $past(cal_reg.current_input_ground))
		else $error("channel grounding wrong");

	// Gain and calibration registers hold zero, voltage gain unity, right after reset
	AST_RESET_ZERO: assert property (@(posedge hclk) disable iff (!hresetn) // see R11
		!$past(hresetn) |-> gain_reg == gain_cfg_t'(GAIN_RESET)
		&& cal_reg == cal_cfg_t'(CAL_RESET) && voltage_gain == GAIN_X1)
		else $error("fields not zero after reset");

	// Indicator read returns the tamper choice one edge on
	AST_ICH_READ: assert property (@(posedge hclk) disable iff (!hresetn) // see R12
		ce && u_slave.state == BUS_READ && reg_hit(bus_req.idx, REG_IDX_ACC_MODE)
		|=> hrdata[ACC_ICH_BIT] == $past(tamper_channel_indicator_reg)
		&& hrdata[ACC_ICH_BIT-1:0] == '0)
		else $error("tamper channel indicator read wrong");

	// Voltage code 000 gives unity
	AST_VGAIN_X1: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
		ce && gain_reg.voltage_gain_sel == GAIN_CODE_X1 |=> voltage_gain == GAIN_X1)
		else $error("voltage gain code 000 not x1");

	// Voltage code 001 gives two
	AST_VGAIN_X2: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
		ce && gain_reg.voltage_gain_sel == GAIN_CODE_X2 |=> voltage_gain == GAIN_X2)
		else $error("voltage gain code 001 not x2");

	// Voltage code 010 gives four
	AST_VGAIN_X4: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
		ce && gain_reg.voltage_gain_sel == GAIN_CODE_X4 |=> voltage_gain == GAIN_X4)
		else $error("voltage gain code 010 not x4");

	// Voltage code 011 gives eight
	AST_VGAIN_X8: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
		ce && gain_reg.voltage_gain_sel == GAIN_CODE_X8 |=> voltage_gain == GAIN_X8)
		else $error("voltage gain code 011 not x8");

	// Current code 000 gives unity
	AST_CGAIN_X1: assert property (@(posedge hclk) disable iff (!hresetn) // see R2
		ce && gain_reg.current_gain_sel == GAIN_CODE_X1 |=> current_gain == GAIN_X1)
		else $error("current gain code 000 not x1");

	// Current code 001 gives two
	AST_CGAIN_X2: assert property (@(posedge hclk) disable iff (!hresetn) // see R2
		ce && gain_reg.current_gain_sel == GAIN_CODE_X2 |=> current_gain == GAIN_X2)
		else $error("current gain code 001 not x2");

	// Current code 010 gives four
	AST_CGAIN_X4: assert property (@(posedge hclk) disable iff (!hresetn) // see R2
		ce && gain_reg.current_gain_sel == GAIN_CODE_X4 |=> current_gain == GAIN_X4)
		else $error("current gain code 010 not x4");

	// Current code 011 gives eight
	AST_CGAIN_X8: assert property (@(posedge hclk) disable iff (!hresetn) // see R2
		ce && gain_reg.current_gain_sel == GAIN_CODE_X8 |=> current_gain == GAIN_X8)
		else $error("current gain code 011 not x8");

	// Current code 100 gives sixteen
	AST_CGAIN_X16: assert property (@(posedge hclk) disable iff (!hresetn) // see R2
		ce && gain_reg.current_gain_sel == GAIN_CODE_X16 |=> current_gain == GAIN_X16)
		else $error("current gain code 100 not x16");

	// Undefined voltage codes give unity
	AST_VGAIN_UNDEF: assert property (@(posedge hclk) disable iff (!hresetn) // see R13
		ce && gain_reg.voltage_gain_sel > GAIN_CODE_X16 |=> voltage_gain == GAIN_X1)
		else $error("undefined voltage gain code not unity");

	// Reserved calibration bits never hold a one
	AST_CAL_RSVD: assert property (@(posedge hclk) disable iff (!hresetn) // see R10
		cal_reg.reserved_hi == '0 && cal_reg.reserved_lo == '0)
		else $error("reserved calibration bits set");

	// First zero-cross pin released and low when disabled
	AST_ZX_IDLE: assert property (@(posedge hclk) disable iff (!hresetn) // see R4
		ce && !zx_cfg_reg.pin_en[ZX_PIN_P12]
		|=> !zx_pin_oe[ZX_PIN_P12] && !zx_pin_out[ZX_PIN_P12])
		else $error("P1.2 driven while disabled");

	// Second zero-cross pin carries the level when enabled
	AST_ZX_P05_OUT: assert property (@(posedge hclk) disable iff (!hresetn) // see R5
		ce |=> zx_pin_out[ZX_PIN_P05] == ($past(zero_cross_level) && zx_pin_oe[ZX_PIN_P05]))
		else $error("P0.5 zero-cross level wrong");

	// Indicator follows the tamper choice one edge late
	AST_ICH_FLOP: assert property (@(posedge hclk) disable iff (!hresetn) // see R12
		ce |=> tamper_channel_indicator_reg == $past(tamper_auto_b))
		else $error("tamper channel indicator stale");

	// Current channel grounding follows its bit
	AST_IGROUND: assert property (@(posedge hclk) disable iff (!hresetn) // see R9
		ce |=> current_input_ground == $past(cal_reg.current_input_ground))
		else $error("current channel grounding wrong");

endmodule : metering_frontend_config_regs
`default_nettype wire

// *** rtl/metering_cfg_pkg.sv ***
`default_nettype none
package metering_cfg_pkg;

	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int IDX_W = 6;
	localparam int IDX_LSB = 2;
	localparam int HTRANS_ACTIVE_BIT = 1;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] REG_IDX_ACC_MODE = 6'h0F;
	localparam logic [IDX_W-1:0] REG_IDX_GAIN = 6'h1B;
	localparam logic [IDX_W-1:0] REG_IDX_ZX = 6'h2B;
	localparam logic [IDX_W-1:0] REG_IDX_CAL = 6'h3D;

	// Field layouts
	typedef struct packed {
		logic [2:0] voltage_gain_sel;
		logic reserved_4;
		logic sign_detect_source;
		logic [2:0] current_gain_sel;
	} gain_cfg_t;

	localparam int ZX_PINS = 2;
	localparam int ZX_PIN_P12 = 0;
	localparam int ZX_PIN_P05 = 1;

	typedef struct packed {
		logic [REG_W-ZX_PINS-1:0] reserved;
		logic [ZX_PINS-1:0] pin_en;
	} zx_cfg_t;

	typedef struct packed {
		logic [1:0] reserved_hi;
		logic [1:0] current_input_select;
		logic voltage_input_ground;
		logic current_input_ground;
		logic [1:0] reserved_lo;
	} cal_cfg_t;

	localparam int ACC_ICH_BIT = 7;

	// Reset values and writable bits
	localparam logic [REG_W-1:0] GAIN_RESET = 8'h00;
	localparam logic [REG_W-1:0] ZX_RESET = 8'h00;
	localparam logic [REG_W-1:0] CAL_RESET = 8'h00;
	localparam logic [REG_W-1:0] GAIN_WRITE_MASK = 8'hEF;
	localparam logic [REG_W-1:0] ZX_WRITE_MASK = 8'h03;
	localparam logic [REG_W-1:0] CAL_WRITE_MASK = 8'h3C;

	// Gain codes and amplification
	localparam int GAIN_W = 5;
	localparam logic [2:0] GAIN_CODE_X1 = 3'h0;
	localparam logic [2:0] GAIN_CODE_X2 = 3'h1;
	localparam logic [2:0] GAIN_CODE_X4 = 3'h2;
	localparam logic [2:0] GAIN_CODE_X8 = 3'h3;
	localparam logic [2:0] GAIN_CODE_X16 = 3'h4;
	localparam logic [GAIN_W-1:0] GAIN_X1 = 5'h01;
	localparam logic [GAIN_W-1:0] GAIN_X2 = 5'h02;
	localparam logic [GAIN_W-1:0] GAIN_X4 = 5'h04;
	localparam logic [GAIN_W-1:0] GAIN_X8 = 5'h08;
	localparam logic [GAIN_W-1:0] GAIN_X16 = 5'h10;

	// Current input selection codes
	localparam logic [1:0] SEL_FORCE_A = 2'h1;
	localparam logic [1:0] SEL_FORCE_B = 2'h2;

	typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} bus_state_t;

	typedef struct packed {
		logic wr_en;
		logic [IDX_W-1:0] idx;
		logic [REG_W-1:0] wdata;
	} bus_req_t;

	// Amplification for a gain code; unused codes give unity
	function automatic logic [GAIN_W-1:0] gain_of(input logic [2:0] code);
		case (code)
			GAIN_CODE_X1: gain_of = GAIN_X1;
			GAIN_CODE_X2: gain_of = GAIN_X2;
			GAIN_CODE_X4: gain_of = GAIN_X4;
			GAIN_CODE_X8: gain_of = GAIN_X8;
			GAIN_CODE_X16: gain_of = GAIN_X16;
			default: gain_of = GAIN_X1;
		endcase
	endfunction : gain_of

endpackage : metering_cfg_pkg
`default_nettype wire

// *** rtl/ahb_reg_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_slave (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [metering_cfg_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [metering_cfg_pkg::DATA_W-1:0] hwdata,
	input wire logic hready,
	input wire logic [metering_cfg_pkg::DATA_W-1:0] rd_word,
	output logic hreadyout,
	output logic hresp,
	output logic [metering_cfg_pkg::DATA_W-1:0] hrdata,
	output var metering_cfg_pkg::bus_req_t bus_req
);
	import metering_cfg_pkg::*;

	bus_state_t state;
	logic [IDX_W-1:0] idx_reg;
	logic size_ok_reg;
	logic addr_take;

	// Address phase accepted
	assign addr_take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;

	// Transfer sequencing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= BUS_IDLE;
		end else if (ce) begin
			unique case (state)
				BUS_IDLE, BUS_WRITE: begin
					if (addr_take) begin
						state <= hwrite ? BUS_WRITE : BUS_READ;
					end else begin
						state <= BUS_IDLE;
					end
				end
				BUS_READ: state <= BUS_IDLE;
			endcase
		end
	end

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_reg <= '0;
			size_ok_reg <= 1'b0;
		end else if (ce && addr_take) begin
			idx_reg <= haddr[IDX_LSB +: IDX_W];
			size_ok_reg <= (hsize == HSIZE_WORD);
		end
	end

	// One wait state on reads, none on writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			hrdata <= '0;
		end else if (ce) begin
			hresp <= HRESP_OKAY;
			if (addr_take && !hwrite) begin
				hreadyout <= 1'b0;
			end else if (state == BUS_READ) begin
				hreadyout <= 1'b1;
				hrdata <= rd_word;
			end
		end
	end

	// Write strobe during the data phase
	always_comb begin
		bus_req.wr_en = ce && (state == BUS_WRITE) && size_ok_reg;
		bus_req.idx = idx_reg;
		bus_req.wdata = hwdata[REG_W-1:0];
	end

endmodule : ahb_reg_slave
`default_nettype wire

// *** rtl/zx_pin_driver.sv ***
`timescale 1ns/1ps
`default_nettype none
module zx_pin_driver (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic enable,
	input wire logic level,
	output logic pin_out,
	output logic pin_oe
);

	// Pin carries the zero-crossing level only while enabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
		end else if (ce) begin
			pin_oe <= enable;
			pin_out <= enable & level;
		end
	end

endmodule : zx_pin_driver
`default_nettype wire

// *** verif/metering_frontend_config_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module metering_frontend_config_regs_test;
	import metering_cfg_pkg::*;

	// One comparison: count it, report a mismatch at once
	`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
		$display("unexpected %s: expected %h seen %h", what, exp, got); end end

	logic hclk, hresetn, ce, hsel, hwrite, tamper_auto_b, zero_cross_level;
	logic [ADDR_W-1:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [DATA_W-1:0] hwdata, hrdata, rd;
	logic hreadyout, hresp, sign_detect_source, meas_use_input_b;
	logic voltage_input_ground, current_input_ground;
	logic [GAIN_W-1:0] voltage_gain, current_gain;
	logic [ZX_PINS-1:0] zx_pin_out, zx_pin_oe;
	int num_errors = 0;
	int checks = 0;

	metering_frontend_config_regs dut (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .tamper_auto_b(tamper_auto_b),
		.zero_cross_level(zero_cross_level), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .voltage_gain(voltage_gain), .current_gain(current_gain),
		.sign_detect_source(sign_detect_source), .meas_use_input_b(meas_use_input_b),
		.voltage_input_ground(voltage_input_ground),
		.current_input_ground(current_input_ground), .zx_pin_out(zx_pin_out),
		.zx_pin_oe(zx_pin_oe)
	);

	// 50 MHz clock
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// Verdict and end of run
	task automatic conclude;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	// Bounded wait for hready high at a rising edge
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 20) begin
				num_errors++;
				$display("unexpected ready wait: expected 1 seen stall");
				conclude();
			end
			@(posedge hclk);
		end
	endtask : wait_ready

	// One single AHB-Lite word transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {idx, 2'h0};
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		wait_ready();
		rd = hrdata;
		`CHK("hresp", HRESP_OKAY, hresp)
	endtask : bus

	// Let a stored value reach the outputs
	task automatic settle;
		repeat (2) @(posedge hclk);
		#1;
	endtask : settle

	// Own reckoning of amplification for a code
	function automatic logic [GAIN_W-1:0] exp_gain(input logic [2:0] c);
		exp_gain = (c <= 3'h4) ? (5'h01 << c) : 5'h01;
	endfunction : exp_gain

	// Values straight after reset
	task automatic test_reset;
		#1;
		`CHK("voltage_gain", GAIN_X1, voltage_gain)
		`CHK("current_gain", GAIN_X1, current_gain)
		`CHK("sign_detect_source", 1'b0, sign_detect_source)
		`CHK("meas_use_input_b", 1'b0, meas_use_input_b)
		`CHK("input grounds", 2'h0, {voltage_input_ground, current_input_ground})
		`CHK("zx_pin_oe", 2'h0, zx_pin_oe)
		`CHK("zx_pin_out", 2'h0, zx_pin_out)
		bus(1'b0, REG_IDX_GAIN, 8'h00);
		`CHK("gain reg", 32'h00000000, rd)
		bus(1'b0, REG_IDX_CAL, 8'h00);
		`CHK("cal reg", 32'h00000000, rd)
	endtask : test_reset

	// Every gain code on both channels, both sign sources
	task automatic test_gain;
		logic [2:0] v, i;
		logic s;
		for (int c = 0; c < 8; c++) begin
			v = c[2:0];
			i = 3'h7 - c[2:0];
			s = c[0];
			bus(1'b1, REG_IDX_GAIN, {v, 1'b1, s, i});
			settle();
			`CHK("voltage_gain", exp_gain(v), voltage_gain)
			`CHK("current_gain", exp_gain(i), current_gain)
			`CHK("sign_detect_source", s, sign_detect_source)
			bus(1'b0, REG_IDX_GAIN, 8'h00);
			`CHK("gain reg", {24'h000000, v, 1'b0, s, i}, rd)
		end
	endtask : test_gain

	// Both zero-cross pins, each enable combination and level
	task automatic test_zx;
		logic [1:0] e;
		for (int k = 0; k < 4; k++) begin
			e = k[1:0];
			bus(1'b1, REG_IDX_ZX, {6'h3F, e});
			for (int lv = 0; lv < 2; lv++) begin
				@(posedge hclk);
				zero_cross_level <= lv[0];
				settle();
				`CHK("zx_pin_oe", e, zx_pin_oe)
				`CHK("zx_pin_out", e & {lv[0], lv[0]}, zx_pin_out)
			end
			bus(1'b0, REG_IDX_ZX, 8'h00);
			`CHK("zx reg", {30'h00000000, e}, rd)
		end
	endtask : test_zx

	// Current input choice and channel grounding
	task automatic test_cal;
		logic [1:0] sel;
		logic exp_b;
		for (int k = 0; k < 8; k++) begin
			sel = k[2:1];
			@(posedge hclk);
			tamper_auto_b <= k[0];
			bus(1'b1, REG_IDX_CAL, {2'h0, sel, sel[0], sel[1], 2'h0});
			settle();
			exp_b = (sel == SEL_FORCE_A) ? 1'b0 : (sel == SEL_FORCE_B) ? 1'b1 : k[0];
			`CHK("meas_use_input_b", exp_b, meas_use_input_b)
			`CHK("voltage_input_ground", sel[0], voltage_input_ground)
			`CHK("current_input_ground", sel[1], current_input_ground)
			bus(1'b0, REG_IDX_CAL, 8'h00);
			`CHK("cal reg", {24'h000000, 2'h0, sel, sel[0], sel[1], 2'h0}, rd)
		end
	endtask : test_cal

	// Tamper indicator is read-only; unmapped place reads zero
	task automatic test_acc;
		@(posedge hclk);
		tamper_auto_b <= 1'b1;
		settle();
		bus(1'b1, REG_IDX_ACC_MODE, 8'h7F);
		bus(1'b0, REG_IDX_ACC_MODE, 8'h00);
		`CHK("acc reg", 32'h00000080, rd)
		@(posedge hclk);
		tamper_auto_b <= 1'b0;
		settle();
		bus(1'b0, REG_IDX_ACC_MODE, 8'h00);
		`CHK("acc reg", 32'h00000000, rd)
		bus(1'b1, 6'h01, 8'h5A);
		bus(1'b0, 6'h01, 8'h00);
		`CHK("unmapped", 32'h00000000, rd)
	endtask : test_acc

	// Clock enable low freezes the input choice
	task automatic test_ce;
		@(posedge hclk);
		ce <= 1'b0;
		tamper_auto_b <= 1'b1;
		settle();
		`CHK("meas_use_input_b", 1'b0, meas_use_input_b)
		@(posedge hclk);
		ce <= 1'b1;
		settle();
		`CHK("meas_use_input_b", 1'b1, meas_use_input_b)
	endtask : test_ce

	// Reset in mid-run clears written fields
	task automatic test_midreset;
		bus(1'b1, REG_IDX_GAIN, 8'h8C);
		bus(1'b1, REG_IDX_CAL, 8'h0C);
		settle();
		`CHK("voltage_gain", GAIN_X16, voltage_gain)
		`CHK("voltage_input_ground", 1'b1, voltage_input_ground)
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		test_reset();
	endtask : test_midreset

	// Main sequence
	initial begin
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h00000000;
		tamper_auto_b = 1'b0;
		zero_cross_level = 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		test_reset();
		test_gain();
		test_zx();
		test_cal();
		test_acc();
		test_ce();
		test_midreset();
		conclude();
	end

endmodule : metering_frontend_config_regs_test
`default_nettype wire
